// [inc/twr_pkg.sv]
package twr_pkg;
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          PUB_HOLD_NS   = 640;
	localparam int          PUB_HOLD_CYC  = (PUB_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          FQ_DEPTH_DEF  = 4;
	localparam logic [4:0]  SLAVE_ADDR_HI = 5'h12;
	localparam logic [2:0]  PTR_TEMP      = 3'h0;
	localparam logic [2:0]  PTR_CFG       = 3'h1;
	localparam logic [2:0]  PTR_HYST      = 3'h2;
	localparam logic [2:0]  PTR_OVH       = 3'h3;
	localparam logic [2:0]  PTR_FLOOR     = 3'h4;
	localparam logic [2:0]  PTR_CEIL      = 3'h5;
	localparam int          TEMP_LSB      = 3;
	localparam int          FLAG_OH       = 2;
	localparam int          FLAG_HI       = 1;
	localparam int          FLAG_LO       = 0;
	localparam int          CFG_SHUTDOWN  = 0;
	localparam int          CFG_EVENT     = 1;
	localparam int          CFG_OH_POL    = 2;
	localparam int          CFG_WIN_POL   = 3;
	localparam int          CFG_FQ_EN     = 4;
	localparam logic [7:0]  CFG_RESET     = 8'h00;
	localparam logic [12:0] FLOOR_RESET   = 13'h00a0;
	localparam logic [12:0] CEIL_RESET    = 13'h0400;
	localparam logic [12:0] OVH_RESET     = 13'h0500;
	localparam logic [12:0] HYST_RESET    = 13'h0020;

	typedef enum logic [4:0] {
		LS_IDLE  = 5'h01,
		LS_ADDR  = 5'h02,
		LS_PTR   = 5'h04,
		LS_WDATA = 5'h08,
		LS_RDATA = 5'h10
	} twr_link_e;

	typedef struct packed {
		logic [2:0]  ptr;
		logic        has_data;
		logic [15:0] data;
	} twr_wr_evt_s;

	typedef struct packed {
		logic out;
		logic oe;
	} twr_od_pin_s;

	typedef struct packed {
		logic        valid;
		logic [12:0] temp;
	} twr_sample_s;
endpackage : twr_pkg

// [rtl/twr_link.sv]
module twr_link (
	input  wire logic                 scl_clk,
	input  wire logic                 srst,
	input  wire logic                 sda_in,
	output      logic                 sda_out,
	output      logic                 sda_oe,
	input  wire logic [1:0]           addr_pins,
	input  wire logic                 pub_tog,
	input  wire logic [15:0]          pub_word,
	output      logic                 wr_tog,
	output      twr_pkg::twr_wr_evt_s wr_evt,
	output      logic                 rd_tog
);
	import twr_pkg::*;

	typedef struct packed {
		twr_link_e   fsm;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic        ack;
		logic        bidx;
		logic [7:0]  hi;
		logic [2:0]  ptr;
		logic [15:0] word;
		logic [7:0]  txsh;
		logic        start_seen;
		logic [1:0]  adr1;
		logic [1:0]  adr2;
		logic        pub1;
		logic        pub2;
		logic        pub_seen;
		logic [15:0] pub_copy;
		logic        wr_tog;
		twr_wr_evt_s evt;
		logic        rd_tog;
	} twr_link_s;

	twr_link_s  cur;
	twr_link_s  next_cur;
	logic       start_tog;
	logic       drive_low;
	logic [7:0] rx_byte;

	// a start is sda falling with scl high; the toggle is settled long before the next scl rise,
	// so the protocol itself gives the setup time that a synchroniser would otherwise buy
	always_ff @(negedge sda_in or posedge srst) begin
		if (srst)
			start_tog <= 1'b0;
		else if (scl_clk)
			start_tog <= ~start_tog;
	end

	always_comb begin
		next_cur = cur;
		rx_byte = {cur.shreg[6:0], sda_in};
		next_cur.adr1 = addr_pins;
		next_cur.adr2 = cur.adr1;
		next_cur.pub1 = pub_tog;
		next_cur.pub2 = cur.pub1;
		if (cur.pub2 != cur.pub_seen) begin
			next_cur.pub_seen = cur.pub2;
			next_cur.pub_copy = pub_word;
		end
		if (start_tog != cur.start_seen) begin
			next_cur.start_seen = start_tog;
			next_cur.fsm = LS_ADDR;
			next_cur.bitcnt = 4'h1;
			next_cur.shreg = rx_byte;
			next_cur.ack = 1'b0;
		end else if (cur.fsm != LS_IDLE && cur.bitcnt == 4'h8) begin
			next_cur.bitcnt = 4'h0;
			next_cur.ack = 1'b0;
			if (cur.fsm == LS_RDATA && !cur.ack) begin
				if (sda_in)
					next_cur.fsm = LS_IDLE;
				else begin
					next_cur.bidx = ~cur.bidx;
					next_cur.txsh = cur.bidx ? cur.word[15:8] : cur.word[7:0];
				end
			end
		end else if (cur.fsm == LS_RDATA) begin
			next_cur.bitcnt = cur.bitcnt + 4'h1;
		end else if (cur.fsm != LS_IDLE) begin
			next_cur.shreg = rx_byte;
			next_cur.bitcnt = cur.bitcnt + 4'h1;
			if (cur.bitcnt == 4'h7) begin
				next_cur.ack = 1'b1;
				case (cur.fsm)
					LS_ADDR: begin
						if (rx_byte[7:1] != {SLAVE_ADDR_HI, cur.adr2}) begin
							next_cur.fsm = LS_IDLE;
							next_cur.ack = 1'b0;
						end else if (rx_byte[0]) begin
							next_cur.fsm = LS_RDATA;
							next_cur.rd_tog = ~cur.rd_tog;
							next_cur.word = cur.pub_copy;
							next_cur.txsh = cur.pub_copy[15:8];
							next_cur.bidx = 1'b0;
						end else
							next_cur.fsm = LS_PTR;
					end
					LS_PTR: begin
						next_cur.fsm = LS_WDATA;
						next_cur.ptr = rx_byte[2:0];
						next_cur.bidx = 1'b0;
						next_cur.evt = '{ptr: rx_byte[2:0], has_data: 1'b0, data: cur.evt.data};
						next_cur.wr_tog = ~cur.wr_tog;
					end
					default: begin
						next_cur.bidx = 1'b1;
						next_cur.hi = rx_byte;
						// config takes one byte, setpoints two, most significant first
						if (cur.bidx || cur.ptr == PTR_CFG) begin
							next_cur.evt = '{ptr: cur.ptr, has_data: 1'b1,
								data: cur.bidx ? {cur.hi, rx_byte} : {rx_byte, 8'h00}};
							next_cur.wr_tog = ~cur.wr_tog;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge scl_clk or posedge srst) begin
		if (srst)
			cur <= '{fsm: LS_IDLE, default: '0};
		else
			cur <= next_cur;
	end

	// data and ack change on the falling edge so they are stable while scl is high
	always_ff @(negedge scl_clk or posedge srst) begin
		if (srst)
			drive_low <= 1'b0;
		else if (cur.bitcnt == 4'h8)
			drive_low <= cur.ack;
		else if (cur.fsm == LS_RDATA)
			drive_low <= ~cur.txsh[3'h7 - cur.bitcnt[2:0]];
		else
			drive_low <= 1'b0;
	end

	assign sda_out = 1'b0;
	assign sda_oe  = drive_low;
	assign wr_tog  = cur.wr_tog;
	assign wr_evt  = cur.evt;
	assign rd_tog  = cur.rd_tog;
endmodule : twr_link

// [rtl/twr_top.sv]
module twr_top #(
	parameter int FQ_DEPTH = twr_pkg::FQ_DEPTH_DEF
) (
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	input  wire logic                 scl_clk,
	input  wire logic                 sda_in,
	output      logic                 sda_out,
	output      logic                 sda_oe,
	input  wire logic [1:0]           addr_pins,
	input  wire twr_pkg::twr_sample_s sample,
	output      logic                 conv_enable,
	output      twr_pkg::twr_od_pin_s win_alarm_pin,
	output      twr_pkg::twr_od_pin_s overheat_alarm_pin
);
	import twr_pkg::*;

	if (FQ_DEPTH < 1 || FQ_DEPTH > 4) begin : g_fq_check
		$error("fault queue depth must lie between 1 and 4");
	end

	typedef struct packed {
		logic [1:0]       wr_sync;
		logic             wr_seen;
		logic [1:0]       rd_sync;
		logic             rd_seen;
		logic [2:0]       ptr;
		logic [7:0]       control_settings;
		logic [12:0]      hysteresis_value;
		logic [12:0]      window_floor_value;
		logic [12:0]      window_ceiling_value;
		logic [12:0]      overheat_setpoint_value;
		logic [12:0]      temp_data;
		logic [2:0]       flags;
		logic [2:0][1:0]  fq_cnt;
		logic             win_act;
		logic             ovh_act;
		twr_od_pin_s      win_pin;
		twr_od_pin_s      ovh_pin;
		logic             conv_en;
		logic [15:0]      pub_word;
		logic             pub_tog;
		logic [7:0]       hold;
	} twr_sys_s;

	localparam twr_sys_s SYS_RESET = '{
		control_settings:        CFG_RESET,
		hysteresis_value:        HYST_RESET,
		window_floor_value:      FLOOR_RESET,
		window_ceiling_value:    CEIL_RESET,
		overheat_setpoint_value: OVH_RESET,
		conv_en:                 1'b1,
		default:                 '0
	};

	twr_sys_s    cur;
	twr_sys_s    next_cur;
	logic        wr_tog;
	logic        rd_tog;
	twr_wr_evt_s wr_evt;
	logic        wr_hit;
	logic        rd_hit;
	logic        conv_hit;
	logic        fq_on;
	logic        out_was;
	logic        out_now;
	logic        sd_next;
	logic [2:0]  want;
	logic [15:0] word;

	function automatic logic signed [13:0] twr_sx(input logic [12:0] v);
		return $signed({v[12], v});
	endfunction : twr_sx

	// unused pointer codes read as zero; setpoint low bits read as zero
	function automatic logic [15:0] twr_read_word(input logic [2:0] p, input twr_sys_s s);
		case (p)
			PTR_TEMP:  return {s.temp_data, s.flags};
			PTR_CFG:   return {s.control_settings, 8'h00};
			PTR_HYST:  return {s.hysteresis_value, 3'h0};
			PTR_OVH:   return {s.overheat_setpoint_value, 3'h0};
			PTR_FLOOR: return {s.window_floor_value, 3'h0};
			PTR_CEIL:  return {s.window_ceiling_value, 3'h0};
			default:   return 16'h0000;
		endcase
	endfunction : twr_read_word

	twr_link u_link (
		.scl_clk   (scl_clk),
		.srst      (srst),
		.sda_in    (sda_in),
		.sda_out   (sda_out),
		.sda_oe    (sda_oe),
		.addr_pins (addr_pins),
		.pub_tog   (cur.pub_tog),
		.pub_word  (cur.pub_word),
		.wr_tog    (wr_tog),
		.wr_evt    (wr_evt),
		.rd_tog    (rd_tog)
	);

	always_comb begin
		next_cur = cur;
		want = cur.flags;
		word = 16'h0000;
		next_cur.wr_sync = {cur.wr_sync[0], wr_tog};
		next_cur.rd_sync = {cur.rd_sync[0], rd_tog};
		wr_hit = cur.wr_sync[1] != cur.wr_seen;
		rd_hit = cur.rd_sync[1] != cur.rd_seen;
		next_cur.wr_seen = cur.wr_sync[1];
		next_cur.rd_seen = cur.rd_sync[1];
		fq_on = cur.control_settings[CFG_FQ_EN];
		// write event payload has been stable for at least two cycles by the time its toggle arrives through the two-flop sync
		if (wr_hit) begin
			next_cur.ptr = wr_evt.ptr;
			if (wr_evt.has_data) begin
				if (wr_evt.ptr == PTR_CFG)
					next_cur.control_settings = wr_evt.data[15:8];
				else if (wr_evt.ptr == PTR_HYST)
					next_cur.hysteresis_value = wr_evt.data[15:TEMP_LSB];
				else if (wr_evt.ptr == PTR_OVH)
					next_cur.overheat_setpoint_value = wr_evt.data[15:TEMP_LSB];
				else if (wr_evt.ptr == PTR_FLOOR)
					next_cur.window_floor_value = wr_evt.data[15:TEMP_LSB];
				else if (wr_evt.ptr == PTR_CEIL)
					next_cur.window_ceiling_value = wr_evt.data[15:TEMP_LSB];
			end
		end
		// no conversions are taken while shut down
		conv_hit = sample.valid && !cur.control_settings[CFG_SHUTDOWN];
		if (conv_hit) begin
			next_cur.temp_data = sample.temp;
			want[FLAG_HI] = cur.flags[FLAG_HI] ?
				!(twr_sx(sample.temp) < twr_sx(cur.window_ceiling_value) - twr_sx(cur.hysteresis_value)) :
				(twr_sx(sample.temp) > twr_sx(cur.window_ceiling_value));
			want[FLAG_LO] = cur.flags[FLAG_LO] ?
				!(twr_sx(sample.temp) > twr_sx(cur.window_floor_value) + twr_sx(cur.hysteresis_value)) :
				(twr_sx(sample.temp) < twr_sx(cur.window_floor_value));
			want[FLAG_OH] = cur.flags[FLAG_OH] ?
				!(twr_sx(sample.temp) < twr_sx(cur.overheat_setpoint_value) - twr_sx(cur.hysteresis_value)) :
				(twr_sx(sample.temp) > twr_sx(cur.overheat_setpoint_value));
			for (int i = 0; i < 3; i++) begin
				if (want[i] == cur.flags[i])
					next_cur.fq_cnt[i] = 2'h0;
				else if (!fq_on || cur.fq_cnt[i] == 2'(FQ_DEPTH - 1)) begin
					next_cur.flags[i] = want[i];
					next_cur.fq_cnt[i] = 2'h0;
				end else
					next_cur.fq_cnt[i] = cur.fq_cnt[i] + 2'h1;
			end
		end
		out_was = cur.flags[FLAG_HI] | cur.flags[FLAG_LO];
		out_now = next_cur.flags[FLAG_HI] | next_cur.flags[FLAG_LO];
		sd_next = next_cur.control_settings[CFG_SHUTDOWN];
		if (next_cur.control_settings[CFG_EVENT]) begin
			// a read and a fresh event in one cycle leave the alarm set
			if (rd_hit)
				next_cur.win_act = 1'b0;
			if (out_now != out_was)
				next_cur.win_act = 1'b1;
		end else
			next_cur.win_act = out_now;
		if (sd_next)
			next_cur.win_act = 1'b0;
		next_cur.ovh_act = next_cur.flags[FLAG_OH] && !sd_next;
		next_cur.win_pin = '{out: 1'b0, oe: next_cur.win_act ^ next_cur.control_settings[CFG_WIN_POL]};
		next_cur.ovh_pin = '{out: 1'b0, oe: next_cur.ovh_act ^ next_cur.control_settings[CFG_OH_POL]};
		next_cur.conv_en = !sd_next;
		// publishing is rate-limited so the link side always sees a settled word
		word = twr_read_word(next_cur.ptr, next_cur);
		if (cur.hold != 8'h00)
			next_cur.hold = cur.hold - 8'h01;
		else if (word != cur.pub_word) begin
			next_cur.pub_word = word;
			next_cur.pub_tog = ~cur.pub_tog;
			next_cur.hold = 8'(PUB_HOLD_CYC);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			cur <= SYS_RESET;
		else
			cur <= next_cur;
	end

	assign conv_enable        = cur.conv_en;
	assign win_alarm_pin      = cur.win_pin;
	assign overheat_alarm_pin = cur.ovh_pin;

	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	a_temp_capture : assert property (
		conv_hit |=> twr_read_word(PTR_TEMP, cur) == {$past(sample.temp), cur.flags}
	) else $error("temperature word did not capture the conversion");

	a_high_trip : assert property (
		conv_hit && !fq_on && !cur.flags[FLAG_HI]
		&& twr_sx(sample.temp) > twr_sx(cur.window_ceiling_value)
		|=> (twr_read_word(PTR_TEMP, cur) & (16'h0001 << FLAG_HI)) != 16'h0000
	) else $error("high flag did not set above the ceiling");

	a_low_hold : assert property (
		conv_hit && cur.flags[FLAG_LO] && !wr_hit
		&& twr_sx(sample.temp) <= twr_sx(cur.window_floor_value) + twr_sx(cur.hysteresis_value)
		|=> cur.flags[FLAG_LO]
	) else $error("low flag released inside its hysteresis band");

	a_overheat_pin : assert property (
		conv_hit && !fq_on && !wr_hit && twr_sx(sample.temp) > twr_sx(cur.overheat_setpoint_value)
		|=> cur.flags[FLAG_OH] && overheat_alarm_pin.oe != cur.control_settings[CFG_OH_POL]
	) else $error("overheat pin not active above the setpoint");

	a_queue_wait : assert property (
		fq_on && !wr_hit && $changed(next_cur.flags[FLAG_HI]) |-> cur.fq_cnt[FLAG_HI] == 2'(FQ_DEPTH - 1)
	) else $error("high flag changed before the fault queue filled");

	a_comp_follow : assert property (
		!cur.control_settings[CFG_EVENT] && !cur.control_settings[CFG_SHUTDOWN]
		|-> win_alarm_pin.oe == ((cur.flags[FLAG_HI] | cur.flags[FLAG_LO]) ^ cur.control_settings[CFG_WIN_POL])
	) else $error("comparator alarm does not follow the window flags");

	a_event_return : assert property (
		cur.control_settings[CFG_EVENT] && !cur.control_settings[CFG_SHUTDOWN] && !wr_hit
		&& $fell(cur.flags[FLAG_HI] | cur.flags[FLAG_LO]) |-> cur.win_act
	) else $error("no event on return inside the window");

	a_read_clear : assert property (
		rd_hit && cur.control_settings[CFG_EVENT] && !wr_hit && !conv_hit |=> !cur.win_act
	) else $error("register read did not clear the event alarm");

	a_shutdown_quiet : assert property (
		wr_hit && wr_evt.has_data && wr_evt.ptr == PTR_CFG && wr_evt.data[8 + CFG_SHUTDOWN]
		|=> !conv_enable && !cur.win_act && !cur.ovh_act
		##1 win_alarm_pin.oe == cur.control_settings[CFG_WIN_POL]
	) else $error("shutdown left an alarm active or conversions running");

	a_cfg_write : assert property (
		wr_hit && wr_evt.has_data && wr_evt.ptr == PTR_CFG |=> cur.control_settings == $past(wr_evt.data[15:8])
	) else $error("configuration write not stored");

	c_event_read : cover property (cur.control_settings[CFG_EVENT] && cur.win_act ##[1:1000] !cur.win_act);
	c_queue_trip : cover property (fq_on && $rose(cur.flags[FLAG_HI]));
	c_overheat : cover property ($rose(cur.ovh_act));
	c_shutdown : cover property ($fell(conv_enable));
endmodule : twr_top

// [tb/twr_host.sv]
module twr_host (
	output logic       scl_clk,
	output logic       sda_level,
	input  wire logic  sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic        host_low;
	logic [15:0] rd_word;
	logic        acks;
	event        rd_done;

	// pull-up wire: low if either side pulls it, high when both release
	assign sda_level = ~(host_low | sda_oe);

	initial begin
		scl_clk = 1'b1;
		host_low = 1'b0;
		acks = 1'b1;
		rd_word = 16'h0000;
	end

	// also serves as repeated start; the link clock stands high between frames
	task automatic start_cond();
		host_low = 1'b0;
		#40 scl_clk = 1'b1;
		#40 host_low = 1'b1;
		#40 scl_clk = 1'b0;
		#40;
	endtask : start_cond

	task automatic stop_cond();
		host_low = 1'b1;
		#40 scl_clk = 1'b1;
		#40 host_low = 1'b0;
		#80;
	endtask : stop_cond

	// data changes only mid-low, sampled mid-high
	task automatic clk_bit(input logic drv_low, output logic seen);
		host_low = drv_low;
		#40 scl_clk = 1'b1;
		#40 seen = sda_level;
		#40 scl_clk = 1'b0;
		#40;
	endtask : clk_bit

	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(~tx[i], b);
			rx[i] = b;
		end
		clk_bit(mack, b);
		ack = ~b;
	endtask : xfer

	task automatic write_reg(input logic [6:0] dev, input logic [2:0] ptr, input logic [15:0] d, input int nb);
		logic [7:0] r;
		logic       a;
		acks = 1'b1;
		start_cond();
		xfer({dev, 1'b0}, 1'b0, r, a);
		acks &= a;
		xfer({5'h00, ptr}, 1'b0, r, a);
		acks &= a;
		if (nb == 2) begin
			xfer(d[15:8], 1'b0, r, a);
			acks &= a;
		end
		xfer(d[7:0], 1'b0, r, a);
		acks &= a;
		stop_cond();
	endtask : write_reg

	task automatic read_reg(input logic [6:0] dev, input logic [2:0] ptr, input int nb);
		logic [7:0] r;
		logic [7:0] hi;
		logic       a;
		start_cond();
		xfer({dev, 1'b0}, 1'b0, r, a);
		xfer({5'h00, ptr}, 1'b0, r, a);
		start_cond();
		xfer({dev, 1'b1}, 1'b0, r, a);
		xfer(8'hff, nb == 2, hi, a);
		r = 8'h00;
		if (nb == 2) begin
			xfer(8'hff, 1'b0, r, a);
		end
		rd_word = {hi, r};
		-> rd_done;
		stop_cond();
	endtask : read_reg
endmodule : twr_host

// [tb/twr_top_tb.sv]
module twr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import twr_pkg::*;

	logic        clk_sys;
	logic        srst;
	wire         scl_clk;
	wire         sda_in;
	logic        sda_out;
	logic        sda_oe;
	logic [1:0]  addr_pins;
	twr_sample_s sample;
	logic        conv_enable;
	twr_od_pin_s win_alarm_pin;
	twr_od_pin_s overheat_alarm_pin;
	int          n_mismatch;
	int          n_checks;
	int          seed;
	logic [31:0] rv;
	logic [15:0] exp_q[$];
	logic [7:0]  cfg;
	logic [12:0] ceil;
	logic [12:0] floor_v;
	logic [12:0] ovh;
	logic [12:0] hyst;
	logic        hi;
	logic        lo;
	logic        oh;
	logic        ev;
	logic [12:0] seq[9] = '{13'h0190, 13'h0401, 13'h03f0, 13'h03df, 13'h0501, 13'h009f, 13'h00b0, 13'h00c1,
		13'h1ff0};

	twr_top u_twr_top (
		.clk_sys            (clk_sys),
		.srst               (srst),
		.scl_clk            (scl_clk),
		.sda_in             (sda_in),
		.sda_out            (sda_out),
		.sda_oe             (sda_oe),
		.addr_pins          (addr_pins),
		.sample             (sample),
		.conv_enable        (conv_enable),
		.win_alarm_pin      (win_alarm_pin),
		.overheat_alarm_pin (overheat_alarm_pin)
	);

	twr_host u_twr_host (
		.scl_clk   (scl_clk),
		.sda_level (sda_in),
		.sda_oe    (sda_oe)
	);

	always #2 clk_sys = ~clk_sys;

	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	// results appear as the host finishes each read
	always begin
		@(u_twr_host.rd_done);
		chk("read_word", exp_q.pop_front(), u_twr_host.rd_word);
	end

	task automatic wreg(input logic [2:0] ptr, input logic [15:0] d);
		u_twr_host.write_reg({SLAVE_ADDR_HI, addr_pins}, ptr, d, (ptr == PTR_CFG) ? 1 : 2);
		case (ptr)
			PTR_CFG:   cfg = d[7:0];
			PTR_HYST:  hyst = d[15:3];
			PTR_OVH:   ovh = d[15:3];
			PTR_FLOOR: floor_v = d[15:3];
			PTR_CEIL:  ceil = d[15:3];
			default:   ;
		endcase
		repeat (10) @(posedge clk_sys);
		#1;
		chk("write_ack", 16'h0001, {15'h0000, u_twr_host.acks});
	endtask : wreg

	task automatic rreg(input logic [2:0] ptr, input logic [15:0] e);
		exp_q.push_back(e);
		u_twr_host.read_reg({SLAVE_ADDR_HI, addr_pins}, ptr, (ptr == PTR_CFG) ? 1 : 2);
		if (cfg[1]) begin
			ev = 1'b0;
		end
		repeat (10) @(posedge clk_sys);
		#1;
	endtask : rreg

	task automatic convert(input logic [12:0] t);
		logic old;
		@(posedge clk_sys);
		sample <= '{valid: 1'b1, temp: t};
		@(posedge clk_sys);
		sample.valid <= 1'b0;
		if (!cfg[0]) begin
			old = hi | lo;
			if ($signed(t) > $signed(ceil)) hi = 1'b1;
			else if ($signed(t) < $signed(ceil - hyst)) hi = 1'b0;
			if ($signed(t) > $signed(ovh)) oh = 1'b1;
			else if ($signed(t) < $signed(ovh - hyst)) oh = 1'b0;
			if ($signed(t) < $signed(floor_v)) lo = 1'b1;
			else if ($signed(t) > $signed(floor_v + hyst)) lo = 1'b0;
			if (cfg[1] && ((hi | lo) != old)) ev = 1'b1;
		end
		// republish of the read word may lag a new result by up to 160 cycles
		repeat (170) @(posedge clk_sys);
		#1;
	endtask : convert

	task automatic check_pins();
		logic wa;
		wa = cfg[0] ? 1'b0 : (cfg[1] ? ev : (hi | lo));
		chk("win_oe", {15'h0000, wa ^ cfg[3]}, {15'h0000, win_alarm_pin.oe});
		chk("ovh_oe", {15'h0000, (oh & ~cfg[0]) ^ cfg[2]}, {15'h0000, overheat_alarm_pin.oe});
		chk("win_out", 16'h0000, {15'h0000, win_alarm_pin.out});
		chk("ovh_out", 16'h0000, {15'h0000, overheat_alarm_pin.out});
		chk("sda_out", 16'h0000, {15'h0000, sda_out});
	endtask : check_pins

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (100000) @(posedge clk_sys);
		n_mismatch++;
		$display("Error timeout expected done seen hang");
		test_done();
	end

	initial begin
		clk_sys = 1'b0;
		srst = 1'b1;
		seed = 60;
		rv = $random(seed);
		addr_pins = rv[1:0];
		sample = '{valid: 1'b0, temp: 13'h0000};
		n_mismatch = 0;
		n_checks = 0;
		{cfg, hi, lo, oh, ev} = '0;
		{ceil, floor_v, ovh, hyst} = {CEIL_RESET, FLOOR_RESET, OVH_RESET, HYST_RESET};
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rreg(PTR_CFG, 16'h0000);
		rreg(PTR_HYST, 16'h0100);
		rreg(PTR_OVH, 16'h2800);
		rreg(PTR_FLOOR, 16'h0500);
		rreg(PTR_CEIL, 16'h2000);
		rreg(PTR_TEMP, 16'h0000);
		$display("test defaults done");
		rv = $random(seed);
		wreg(PTR_OVH, rv[15:0]);
		rreg(PTR_OVH, rv[15:0] & 16'hfff8);
		wreg(PTR_OVH, 16'h2800);
		wreg(PTR_TEMP, 16'hffff);
		rreg(PTR_TEMP, 16'h0000);
		$display("test setpoint access done");
		foreach (seq[i]) begin
			convert(seq[i]);
			check_pins();
			rreg(PTR_TEMP, {seq[i], oh, hi, lo});
		end
		wreg(PTR_CFG, 16'h000c);
		check_pins();
		wreg(PTR_CFG, 16'h0000);
		$display("test comparator done");
		convert(13'h0190);
		wreg(PTR_CFG, 16'h0002);
		rreg(PTR_TEMP, {13'h0190, 3'h0});
		check_pins();
		convert(13'h0401);
		check_pins();
		rreg(PTR_TEMP, {13'h0401, 3'h2});
		check_pins();
		wreg(PTR_CEIL, 16'h2400);
		convert(13'h0401);
		check_pins();
		rreg(PTR_TEMP, {13'h0401, 3'h0});
		check_pins();
		$display("test event done");
		wreg(PTR_CFG, 16'h0010);
		for (int k = 0; k < 4; k++) begin
			convert(13'h0490);
			if (k < 3) chk("fq_win_oe", 16'h0000, {15'h0000, win_alarm_pin.oe});
			else check_pins();
		end
		$display("test fault queue done");
		wreg(PTR_CFG, 16'h0001);
		chk("conv_en", 16'h0000, {15'h0000, conv_enable});
		check_pins();
		convert(13'h0190);
		rreg(PTR_TEMP, {13'h0490, 3'h2});
		wreg(PTR_CFG, 16'h0000);
		chk("conv_en", 16'h0001, {15'h0000, conv_enable});
		check_pins();
		$display("test shutdown done");
		u_twr_host.write_reg({SLAVE_ADDR_HI, ~addr_pins}, PTR_CFG, 16'h0004, 1);
		chk("foreign_ack", 16'h0000, {15'h0000, u_twr_host.acks});
		rreg(PTR_CFG, 16'h0000);
		$display("test foreign address done");
		#1;
		test_done();
	end
endmodule : twr_top_tb
